// ===== design/bank_if.sv
// Purpose: Control and status of one bank between sequencer and tracker
// Assumes: One instance per bank
// Notes: clk_en low freezes the tracker
`timescale 1ns/1ns
interface bank_if;
	logic activate;
	logic precharge;
	logic clk_en;
	logic is_open;
	logic ready;

	modport ctrl (output activate, output precharge, output clk_en, input is_open, input ready);
	modport bank (input activate, input precharge, input clk_en, output is_open, output ready);
endinterface : bank_if

// ===== design/bank_tracker.sv
// Purpose: Open state and precharge timer of one bank
// Assumes: Activate only when ready and closed
// Notes: Timer stops while the internal clock is gated
`timescale 1ns/1ns
`include "sdram_suspend_map.svh"
module bank_tracker #(
	parameter int unsigned PRECHARGE_CYCLES = `PRECHARGE_CYC
)(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Sequencer side
	bank_if.bank bus
);

	logic [7:0] rp_cnt_r;
	logic open_r;
	logic ready_r;

	assign bus.is_open = open_r;
	assign bus.ready = ready_r;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			open_r <= 1'b0;
			ready_r <= 1'b1;
			rp_cnt_r <= 8'h00;
		end
		else if (bus.clk_en)
		begin
			if (bus.precharge && open_r)
			begin
				open_r <= 1'b0;
				ready_r <= 1'b0;
				rp_cnt_r <= 8'(PRECHARGE_CYCLES - 1);
			end
			else if (bus.activate)
				open_r <= 1'b1;
			else if (!ready_r)
			begin
				if (rp_cnt_r == 8'h00)
					ready_r <= 1'b1;
				else
					rp_cnt_r <= rp_cnt_r - 8'h01;
			end
		end
	end

endmodule : bank_tracker

// ===== design/sdram_clock_suspend_control.sv
// Purpose: Clock-gate handling, suspend, power-down and auto-precharge timing
// Assumes: Pins are asynchronous to clock; config inputs are static
// Notes: Full-page bursts are not supported here
`timescale 1ns/1ns
`include "sdram_suspend_map.svh"
module sdram_clock_suspend_control
	import sdram_suspend_pkg::*;
#(
	parameter int unsigned NUM_BANKS = `NUM_BANKS,
	parameter int unsigned PRECHARGE_CYCLES = `PRECHARGE_CYC
)(
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Command pins
	input wire logic clock_gate,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] bank_sel,
	input wire logic auto_precharge_address_bit,
	// Static configuration
	input wire logic [1:0] burst_len_code,
	input wire logic [1:0] cas_latency,
	// Status
	output logic suspended_r,
	output logic power_down_r,
	output logic internal_clock_en_r,
	output logic burst_active_r,
	output logic cmd_taken_r,
	output logic cmd_ignored_r,
	output logic internal_precharge_start_r,
	output logic [1:0] precharge_bank_r,
	output logic [NUM_BANKS-1:0] bank_open,
	output logic [NUM_BANKS-1:0] bank_ready
);

	logic [7:0] pin_s1_r;
	logic [7:0] pin_s2_r;
	mode_e mode_r;
	mode_e mode_nxt;
	logic susp_req_r;
	logic pd_req_r;
	logic wake_r;
	logic [3:0] burst_left_r;
	logic [1:0] burst_bank_r;
	logic burst_ap_r;
	logic burst_wr_r;
	logic ap_fired_r;
	logic dpl_wait_r;

	// Gate, chip select, command, bank and A10 travel together so they stay aligned
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_s1_r <= `RST_PIN_SYNC;
			pin_s2_r <= `RST_PIN_SYNC;
		end
		else
		begin
			pin_s1_r <= {clock_gate, cs_n, ras_n, cas_n, we_n, bank_sel, auto_precharge_address_bit};
			pin_s2_r <= pin_s1_r;
		end
	end

	logic gate_q;
	logic cs_n_q;
	cmd_e cmd_q;
	logic [1:0] bank_q;
	logic ap_bit_q;
	logic run;
	logic any_open;
	logic cmd_valid;
	logic act_go;
	logic rw_go;
	logic pre_go;
	logic halt_go;
	logic last_beat;
	logic [3:0] burst_len;
	logic [3:0] read_lead;
	logic read_ap_now;
	logic ap_start;

	assign gate_q = pin_s2_r[7];
	assign cs_n_q = pin_s2_r[6];
	assign cmd_q = cmd_e'(pin_s2_r[5:3]);
	assign bank_q = pin_s2_r[2:1];
	assign ap_bit_q = pin_s2_r[0];
	assign run = (mode_r == MODE_RUN);
	assign any_open = |bank_open;
	assign burst_len = 4'h1 << burst_len_code;
	assign read_lead = {2'b00, cas_latency} - 4'h1;

	// Auto-precharge bursts refuse read, write and precharge until done
	assign cmd_valid = run && !cs_n_q;
	assign act_go = cmd_valid && (cmd_q == CMD_ACTIVATE) && bank_ready[bank_q] && !bank_open[bank_q];
	assign rw_go = cmd_valid && ((cmd_q == CMD_READ) || (cmd_q == CMD_WRITE))
		&& bank_open[bank_q] && !(burst_active_r && burst_ap_r);
	assign pre_go = cmd_valid && (cmd_q == CMD_PRECHARGE) && !(burst_active_r && burst_ap_r);
	assign halt_go = cmd_valid && (cmd_q == CMD_BURST_HALT) && !(burst_active_r && burst_ap_r);
	assign last_beat = burst_active_r && (burst_left_r == 4'h1);

	// Read precharge fires once when the remaining beats reach the latency lead
	assign read_ap_now = run && burst_active_r && !burst_wr_r && burst_ap_r && !ap_fired_r
		&& (burst_left_r <= read_lead);
	assign ap_start = (run && dpl_wait_r) || read_ap_now;

	// Gate sampled low takes effect one edge later, so the next edge still advances
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			susp_req_r <= 1'b0;
			pd_req_r <= 1'b0;
			wake_r <= 1'b0;
		end
		else
		begin
			susp_req_r <= !gate_q && any_open;
			pd_req_r <= !gate_q && !any_open;
			wake_r <= gate_q;
		end
	end

	always_comb
	begin
		mode_nxt = mode_r;
		case (mode_r)
			MODE_RUN:
			begin
				if (susp_req_r)
					mode_nxt = MODE_SUSPEND;
				else if (pd_req_r)
					mode_nxt = MODE_POWER_DOWN;
			end
			MODE_SUSPEND:
			begin
				if (wake_r)
					mode_nxt = MODE_RUN;
			end
			MODE_POWER_DOWN:
			begin
				if (wake_r)
					mode_nxt = MODE_RUN;
			end
			default:
				mode_nxt = MODE_RUN;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_r <= MODE_RUN;
			suspended_r <= 1'b0;
			power_down_r <= 1'b0;
			internal_clock_en_r <= 1'b1;
		end
		else
		begin
			mode_r <= mode_nxt;
			suspended_r <= (mode_nxt == MODE_SUSPEND);
			power_down_r <= (mode_nxt == MODE_POWER_DOWN);
			internal_clock_en_r <= (mode_nxt == MODE_RUN);
		end
	end

	// Burst sequencer only moves on enabled edges, so a burst holds mid-flight
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			burst_active_r <= 1'b0;
			burst_left_r <= `RST_BURST_LEFT;
			burst_bank_r <= 2'h0;
			burst_ap_r <= 1'b0;
			burst_wr_r <= 1'b0;
			ap_fired_r <= 1'b0;
		end
		else if (run)
		begin
			if (rw_go)
			begin
				burst_active_r <= 1'b1;
				burst_left_r <= burst_len;
				burst_bank_r <= bank_q;
				burst_ap_r <= ap_bit_q;
				burst_wr_r <= (cmd_q == CMD_WRITE);
				ap_fired_r <= 1'b0;
			end
			else if (halt_go && burst_active_r)
				burst_active_r <= 1'b0;
			else if (burst_active_r)
			begin
				burst_left_r <= burst_left_r - 4'h1;
				if (last_beat)
					burst_active_r <= 1'b0;
				if (read_ap_now)
					ap_fired_r <= 1'b1;
			end
		end
	end

	// Write recovery: precharge waits one enabled edge past the last data beat
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			dpl_wait_r <= 1'b0;
		else if (run)
			dpl_wait_r <= last_beat && burst_wr_r && burst_ap_r && !rw_go;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			internal_precharge_start_r <= 1'b0;
			precharge_bank_r <= 2'h0;
			cmd_taken_r <= 1'b0;
			cmd_ignored_r <= 1'b0;
		end
		else
		begin
			internal_precharge_start_r <= ap_start;
			if (ap_start)
				precharge_bank_r <= burst_bank_r;
			cmd_taken_r <= act_go || rw_go || pre_go || halt_go;
			cmd_ignored_r <= !run && !cs_n_q && (cmd_q != CMD_NOP);
		end
	end

	bank_if bif [NUM_BANKS] ();

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++)
		begin : g_bank
			assign bif[gi].clk_en = run;
			assign bif[gi].activate = act_go && (bank_q == 2'(gi));
			// Precharge reaches the tracker when the bank's timer may start
			assign bif[gi].precharge = (pre_go && (ap_bit_q || (bank_q == 2'(gi))))
				|| (ap_start && (burst_bank_r == 2'(gi)));
			assign bank_open[gi] = bif[gi].is_open;
			assign bank_ready[gi] = bif[gi].ready;

			bank_tracker #(
				.PRECHARGE_CYCLES(PRECHARGE_CYCLES)
			) u_bank (
				.clock(clock),
				.rst_n(rst_n),
				.bus(bif[gi].bank)
			);
		end
	endgenerate

	a_suspend_entry: assert property (@(posedge clock) disable iff (!rst_n)
		(run && !gate_q && any_open) |-> ##2 (mode_r == MODE_SUSPEND))
		else $error("suspend not entered after gate low");
	a_burst_frozen: assert property (@(posedge clock) disable iff (!rst_n)
		(mode_r == MODE_SUSPEND) |=> ($stable(burst_left_r) && $stable(burst_active_r)))
		else $error("burst moved while suspended");
	a_suspend_delay: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(suspended_r) |-> ($past(susp_req_r) && $past(run) && !$past(gate_q, 2)))
		else $error("suspend without one clock delay");
	a_cmd_ignored: assert property (@(posedge clock) disable iff (!rst_n)
		!run |=> !cmd_taken_r)
		else $error("command taken while not running");
	// Only the first high sample counts; wake_r marks the later ones
	a_resume_delay: assert property (@(posedge clock) disable iff (!rst_n)
		(mode_r == MODE_SUSPEND && gate_q && !wake_r) |-> ##1 !run ##1 run)
		else $error("resume timing wrong");
	a_write_recovery: assert property (@(posedge clock) disable iff (!rst_n)
		(run && last_beat && burst_wr_r && burst_ap_r && !rw_go) ##1 run
		|=> (internal_precharge_start_r && precharge_bank_r == $past(burst_bank_r, 2)))
		else $error("write auto-precharge not one clock after data");
	a_read_lead: assert property (@(posedge clock) disable iff (!rst_n)
		(run && burst_active_r && !burst_wr_r && burst_ap_r && (burst_left_r == read_lead))
		|=> internal_precharge_start_r)
		else $error("read auto-precharge start wrong");
	a_power_down: assert property (@(posedge clock) disable iff (!rst_n)
		(run && !gate_q && !any_open) |-> ##2 (mode_r == MODE_POWER_DOWN))
		else $error("power-down not entered with banks idle");

endmodule : sdram_clock_suspend_control

// ===== design/sdram_suspend_map.svh
// Purpose: Timing counts and reset values for the clock suspend block
// Assumes: 250 MHz core clock
// Notes: Least times round up to whole cycles
`ifndef SDRAM_SUSPEND_MAP_SVH
`define SDRAM_SUSPEND_MAP_SVH

`define CLK_PERIOD_NS 4
`define PRECHARGE_NS 20
`define PRECHARGE_CYC ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NUM_BANKS 4
`define RST_BURST_LEFT 4'h0
`define RST_PIN_SYNC 8'hff

`endif

// ===== design/sdram_suspend_pkg.sv
// Purpose: Types shared by the clock suspend block
// Assumes: Command code is {ras_n, cas_n, we_n} with cs_n low
// Notes: Refresh and mode-set codes are handled elsewhere
package sdram_suspend_pkg;

	typedef enum logic [2:0]
	{
		CMD_MODE_SET = 3'h0,
		CMD_REFRESH = 3'h1,
		CMD_PRECHARGE = 3'h2,
		CMD_ACTIVATE = 3'h3,
		CMD_WRITE = 3'h4,
		CMD_READ = 3'h5,
		CMD_BURST_HALT = 3'h6,
		CMD_NOP = 3'h7
	} cmd_e;

	typedef enum logic [2:0]
	{
		MODE_RUN = 3'h1,
		MODE_SUSPEND = 3'h2,
		MODE_POWER_DOWN = 3'h4
	} mode_e;

endpackage : sdram_suspend_pkg

// ===== test/ctrl_model.sv
// Purpose: Behavioural memory controller driving the command pins
// Assumes: Caller acts just after a rising clock edge
// Notes: Bank lines show inverted values once released
`timescale 1ns/1ns
module ctrl_model
	import sdram_suspend_pkg::*;
(
	// Clock
	input wire logic clock,
	// Pins toward the device
	output logic clock_gate,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] bank_sel,
	output logic auto_precharge_address_bit,
	// Read data mask
	output logic byte_mask
);
	logic last_read;

	initial
	begin
		byte_mask = 1'b0;
		last_read = 1'b0;
		clock_gate = 1'b1;
		cs_n = 1'b0;
		{ras_n, cas_n, we_n} = CMD_NOP;
		bank_sel = 2'h0;
		auto_precharge_address_bit = 1'b0;
	end

	// One cycle only, so a stale command is never taken twice
	task automatic issue(input cmd_e c, input logic [1:0] b, input logic ap);
		{ras_n, cas_n, we_n} = c;
		bank_sel = b;
		auto_precharge_address_bit = ap;
		byte_mask = (c == CMD_WRITE) && last_read;
		last_read = (c == CMD_READ);
		@(posedge clock);
		#1;
		byte_mask = 1'b0;
		{ras_n, cas_n, we_n} = CMD_NOP;
		bank_sel = ~b;
		auto_precharge_address_bit = ~ap;
	endtask : issue

	task automatic set_gate(input logic v);
		clock_gate = v;
	endtask : set_gate
endmodule : ctrl_model

// ===== test/tb_top.sv
// Purpose: Self-checking bench for the clock suspend block
// Assumes: Burst length and latency change only while idle
// Notes: Precharge count shortened to keep the run brief
`timescale 1ns/1ns
module tb_top
	import sdram_suspend_pkg::*;
;
	localparam int PRE = 4;
	typedef struct packed
	{
		cmd_e cmd;
		logic [1:0] bank;
		logic ap;
		logic taken;
		logic [3:0] open;
	} row_s;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic clock_gate, cs_n, ras_n, cas_n, we_n, auto_precharge_address_bit;
	logic [1:0] bank_sel;
	logic suspended_r, power_down_r, internal_clock_en_r, burst_active_r;
	logic cmd_taken_r, cmd_ignored_r, internal_precharge_start_r;
	logic [1:0] precharge_bank_r;
	logic [3:0] bank_open, bank_ready;
	logic [1:0] burst_len_code = 2'h3;
	logic [1:0] cas_latency = 2'h3;
	int failures = 0;
	int check_count = 0;
	int cycles = 0;
	row_s rows [10] = '{
		'{CMD_ACTIVATE, 2'h0, 1'b0, 1'b1, 4'h1},
		'{CMD_ACTIVATE, 2'h0, 1'b0, 1'b0, 4'h1},
		'{CMD_ACTIVATE, 2'h1, 1'b0, 1'b1, 4'h3},
		'{CMD_READ, 2'h2, 1'b0, 1'b0, 4'h3},
		'{CMD_PRECHARGE, 2'h1, 1'b0, 1'b1, 4'h1},
		'{CMD_REFRESH, 2'h0, 1'b0, 1'b0, 4'h1},
		'{CMD_MODE_SET, 2'h0, 1'b0, 1'b0, 4'h1},
		'{CMD_READ, 2'h0, 1'b0, 1'b1, 4'h1},
		'{CMD_BURST_HALT, 2'h0, 1'b0, 1'b1, 4'h1},
		'{CMD_WRITE, 2'h0, 1'b0, 1'b1, 4'h1}};

	always #2 clock = ~clock;

	ctrl_model ctl (.clock(clock), .clock_gate(clock_gate), .cs_n(cs_n), .ras_n(ras_n),
		.cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel),
		.auto_precharge_address_bit(auto_precharge_address_bit), .byte_mask());

	sdram_clock_suspend_control #(.PRECHARGE_CYCLES(PRE)) uut (
		.clock(clock), .rst_n(rst_n), .clock_gate(clock_gate), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel),
		.auto_precharge_address_bit(auto_precharge_address_bit),
		.burst_len_code(burst_len_code), .cas_latency(cas_latency), .suspended_r(suspended_r),
		.power_down_r(power_down_r), .internal_clock_en_r(internal_clock_en_r),
		.burst_active_r(burst_active_r), .cmd_taken_r(cmd_taken_r),
		.cmd_ignored_r(cmd_ignored_r), .internal_precharge_start_r(internal_precharge_start_r),
		.precharge_bank_r(precharge_bank_r), .bank_open(bank_open), .bank_ready(bank_ready));

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : tick

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Start edge: two sync edges, the action edge, then length less latency lead
	task automatic read_ap(input logic [1:0] b, input logic [7:0] exp_at, input logic exp_act);
		logic [7:0] at;
		logic act;
		at = 8'h00;
		act = 1'b0;
		ctl.issue(CMD_ACTIVATE, b, 1'b0);
		tick(PRE);
		ctl.issue(CMD_READ, b, 1'b1);
		for (int j = 1; j <= 14; j++)
		begin
			tick(1);
			if (internal_precharge_start_r === 1'b1)
			begin
				at = 8'(j);
				act = burst_active_r;
			end
		end
		check(at, exp_at);
		check({act, bank_open[b]}, {exp_act, 1'b0});
	endtask : read_ap

	task automatic tally_and_finish;
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	// Run is about 165 cycles; twelve times that means a hang
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			failures++;
			tally_and_finish();
		end
	end

	initial
	begin
		tick(5);
		check({suspended_r, power_down_r, internal_clock_en_r}, 8'h1);
		check({bank_open, bank_ready}, 8'h0f);
		@(posedge clock);
		#1;
		rst_n = 1'b1;
		tick(1);
		foreach (rows[i])
		begin
			ctl.issue(rows[i].cmd, rows[i].bank, rows[i].ap);
			tick(2);
			check({cmd_ignored_r, cmd_taken_r}, {1'b0, rows[i].taken});
			check(bank_open, rows[i].open);
		end
		// Suspend in mid-burst with bank 0 open
		ctl.issue(CMD_READ, 2'h0, 1'b0);
		ctl.set_gate(1'b0);
		tick(3);
		check({suspended_r, burst_active_r}, 8'h1);
		tick(1);
		check({suspended_r, power_down_r, internal_clock_en_r}, 8'h4);
		ctl.issue(CMD_ACTIVATE, 2'h2, 1'b0);
		tick(2);
		check(cmd_ignored_r, 1'b1);
		tick(20);
		check({burst_active_r, bank_open}, 8'h11);
		ctl.set_gate(1'b1);
		tick(3);
		check(suspended_r, 1'b1);
		tick(1);
		check({suspended_r, internal_clock_en_r}, 8'h1);
		tick(12);
		check(burst_active_r, 1'b0);
		// All banks idle: gate low gives power-down
		ctl.issue(CMD_PRECHARGE, 2'h0, 1'b1);
		tick(PRE + 4);
		check(bank_open, 4'h0);
		ctl.set_gate(1'b0);
		tick(4);
		check({suspended_r, power_down_r}, 8'h1);
		ctl.issue(CMD_ACTIVATE, 2'h3, 1'b0);
		tick(2);
		check(cmd_ignored_r, 1'b1);
		ctl.set_gate(1'b1);
		tick(4);
		check({power_down_r, internal_clock_en_r}, 8'h1);
		tick(2);
		check(bank_open, 4'h0);
		// Write with auto-precharge, burst of 8
		ctl.issue(CMD_ACTIVATE, 2'h2, 1'b0);
		tick(PRE);
		ctl.issue(CMD_WRITE, 2'h2, 1'b1);
		tick(10);
		check(internal_precharge_start_r, 1'b0);
		tick(1);
		check({internal_precharge_start_r, precharge_bank_r, bank_open[2], bank_ready[2]}, 8'h18);
		tick(PRE - 1);
		check(bank_ready, 4'hb);
		tick(1);
		check(bank_ready, 4'hf);
		// Read with auto-precharge: length 8, latency 3, then length 4, latency 2
		read_ap(2'h1, 8'h09, 1'b1);
		burst_len_code = 2'h2;
		cas_latency = 2'h2;
		read_ap(2'h1, 8'h06, 1'b0);
		tally_and_finish();
	end
endmodule : tb_top
